// ### shared/tcas_consts.vh
/*
  Constants for the three-channel conversion sequencer: mode codes,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock; included by its bare name.
*/
`ifndef TCAS_CONSTS_VH
`define TCAS_CONSTS_VH

// ----------------------------------------------------------------------
// Mode field (bits 2..0 of configuration)
// ----------------------------------------------------------------------
`define TCAS_MODE_MSB 2
`define TCAS_MODE_LSB 0
`define TCAS_MODE_PD0 3'h0
`define TCAS_MODE_SS_SHUNT 3'h1
`define TCAS_MODE_SS_BUS 3'h2
`define TCAS_MODE_SS_BOTH 3'h3
`define TCAS_MODE_PD4 3'h4
`define TCAS_MODE_CT_SHUNT 3'h5
`define TCAS_MODE_CT_BUS 3'h6
`define TCAS_MODE_CT_BOTH 3'h7
`define TCAS_MODE_RESET 3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TCAS_CLK_MHZ 100
`define TCAS_TOUT_MS 28
`define TCAS_TOUT_CYC (`TCAS_TOUT_MS * 1000 * `TCAS_CLK_MHZ)
`define TCAS_WAKE_US 40
`define TCAS_WAKE_CYC (`TCAS_WAKE_US * `TCAS_CLK_MHZ)
`define TCAS_BUS_LSB_MV 8'h08

`endif

// ### design/tcas_result_mem.v
/*
  Small result store: one 16-bit word per channel and quantity.
  Assumes a single clock; read data come out of a register.
*/
`timescale 1ns/1ps
`default_nettype none

module tcas_result_mem #(
  parameter AW = 3,
  parameter DW = 16
) (
  input wire sys_clk_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered read; a read of the word being written sees old data
  always @(posedge sys_clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem[rd_addr_i];
  end

endmodule // tcas_result_mem

`default_nettype wire

// ### design/tcas_sequencer.v
/*
  Conversion sequencer of a three-channel shunt and bus monitor.
  Steps through enabled channels, keeps results, drives the ready flag,
  and watches the serial clock for a low-clock timeout.
  Assumes: conversions are done by an external converter handshake
  (start pulse, done pulse with data) on sys_clk_i; config writes and
  mask/enable reads arrive as one-cycle strobes from the serial slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcas_consts.vh"

module tcas_sequencer #(
  parameter TOUT_CYC = `TCAS_TOUT_CYC,
  parameter WAKE_CYC = `TCAS_WAKE_CYC,
  parameter DW = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire cfg_wr_i,
  input wire [2:0] cfg_mode_i,
  input wire [2:0] cfg_chan_en_i,
  input wire mask_rd_i,
  input wire adc_done_i,
  input wire [DW-1:0] adc_data_i,
  input wire [2:0] res_addr_i,
  output reg [2:0] mode_o,
  output reg [2:0] chan_en_o,
  output reg conversion_ready_flag_o,
  output reg adc_start_o,
  output reg [1:0] adc_chan_o,
  output reg adc_is_bus_o,
  output reg adc_power_o,
  output reg busy_o,
  output reg serial_reset_o,
  output reg [DW-1:0] res_data_o,
  output reg [7:0] bus_lsb_mv_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam ST_DOWN = 3'h0;
  localparam ST_WAKE = 3'h1;
  localparam ST_PICK = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_WAIT = 3'h4;
  localparam ST_NEXT = 3'h5;

  reg [2:0] state;
  reg [1:0] chan;
  reg is_bus;
  reg [31:0] wake_cnt;
  reg [31:0] tout_cnt;
  reg scl_meta;
  reg scl_sync;
  reg pend_start;
  wire [DW-1:0] mem_rd;

  // Mode decode
  wire mode_pd = (mode_o == `TCAS_MODE_PD0) || (mode_o == `TCAS_MODE_PD4);
  wire mode_cont = mode_o[2];
  wire do_shunt = mode_o[0];
  wire do_bus = mode_o[1];
  wire new_pd = (cfg_mode_i == `TCAS_MODE_PD0) ||
                (cfg_mode_i == `TCAS_MODE_PD4);

  // Lowest enabled channel at or after a given index
  function [2:0] tcas_find;
    input [2:0] en;
    input [1:0] from;
    begin
      tcas_find = 3'h4;
      if (from <= 2'h2 && en[2])
        tcas_find = 3'h2;
      if (from <= 2'h1 && en[1])
        tcas_find = 3'h1;
      if (from == 2'h0 && en[0])
        tcas_find = 3'h0;
    end
  endfunction

  wire [2:0] first_ch = tcas_find(chan_en_o, 2'h0);
  wire [2:0] next_ch = (chan == 2'h2) ? 3'h4 :
                       tcas_find(chan_en_o, chan + 2'h1);

  // --------------------------------------------------------------------
  // Serial clock timeout
  // --------------------------------------------------------------------
  // Two stages before use: the pin is asynchronous to sys_clk_i
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
    end
  end

  // Count low time; pulse reset once the typical timeout is passed
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tout_cnt <= 32'h0;
      serial_reset_o <= 1'b0;
    end
    else
    begin
      serial_reset_o <= 1'b0;
      if (scl_sync)
        tout_cnt <= 32'h0;
      else if (tout_cnt < TOUT_CYC)
      begin
        tout_cnt <= tout_cnt + 32'h1;
        if (tout_cnt == TOUT_CYC - 1)
          serial_reset_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Configuration and ready flag
  // --------------------------------------------------------------------
  // Set wins over a same-cycle clear so a finished pass is never lost
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_o <= `TCAS_MODE_RESET;
      chan_en_o <= 3'h7;
      conversion_ready_flag_o <= 1'b0;
    end
    else
    begin
      if (cfg_wr_i)
      begin
        mode_o <= cfg_mode_i;
        chan_en_o <= cfg_chan_en_i;
      end
      if (state == ST_NEXT && next_ch[2] && pend_start == 1'b0)
        conversion_ready_flag_o <= 1'b1;
      else if ((cfg_wr_i && !new_pd) || mask_rd_i)
        conversion_ready_flag_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // A write restarts the pass from the lowest channel; applied one
  // cycle later, once the new mode and enables are in their registers
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_WAKE;
      chan <= 2'h0;
      is_bus <= 1'b0;
      wake_cnt <= 32'h0;
      pend_start <= 1'b0;
      adc_start_o <= 1'b0;
      adc_chan_o <= 2'h0;
      adc_is_bus_o <= 1'b0;
      adc_power_o <= 1'b1;
      busy_o <= 1'b0;
    end
    else
    begin
      adc_start_o <= 1'b0;
      pend_start <= cfg_wr_i;
      if (pend_start)
      begin
        if (mode_pd)
        begin
          state <= ST_DOWN;
          adc_power_o <= 1'b0;
          busy_o <= 1'b0;
        end
        else if (state == ST_WAKE)
        begin
          // Recovery still running: a new mode must not cut it short
          busy_o <= 1'b1;
        end
        else if (!adc_power_o)
        begin
          state <= ST_WAKE;
          wake_cnt <= 32'h0;
          adc_power_o <= 1'b1;
          busy_o <= 1'b1;
        end
        else
        begin
          state <= ST_PICK;
          busy_o <= 1'b1;
        end
      end
      else
      begin
        case (state)
          ST_DOWN:
          begin
            busy_o <= 1'b0;
          end
          ST_WAKE:
          begin
            busy_o <= 1'b1;
            if (wake_cnt >= WAKE_CYC - 1)
              state <= ST_PICK;
            else
              wake_cnt <= wake_cnt + 32'h1;
          end
          ST_PICK:
          begin
            if (first_ch[2])
            begin
              // Nothing enabled: pass is empty and ends at once
              chan <= 2'h2;
              state <= ST_NEXT;
            end
            else
            begin
              chan <= first_ch[1:0];
              is_bus <= !do_shunt;
              state <= ST_CONV;
            end
          end
          ST_CONV:
          begin
            adc_start_o <= 1'b1;
            adc_chan_o <= chan;
            adc_is_bus_o <= is_bus;
            state <= ST_WAIT;
          end
          ST_WAIT:
          begin
            if (adc_done_i)
            begin
              if (!is_bus && do_bus)
              begin
                is_bus <= 1'b1;
                state <= ST_CONV;
              end
              else
                state <= ST_NEXT;
            end
          end
          ST_NEXT:
          begin
            if (!next_ch[2])
            begin
              chan <= next_ch[1:0];
              is_bus <= !do_shunt;
              state <= ST_CONV;
            end
            else if (mode_cont)
              state <= ST_PICK;
            else
            begin
              state <= ST_DOWN;
              adc_power_o <= 1'b0;
              busy_o <= 1'b0;
            end
          end
          default:
          begin
            state <= ST_DOWN;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Results
  // --------------------------------------------------------------------
  // Only completed conversions are stored, so reads always see the
  // latest finished value, also in power-down
  tcas_result_mem #(
    .AW(3),
    .DW(DW)
  ) u_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(state == ST_WAIT && adc_done_i),
    .wr_addr_i({is_bus, chan}),
    .wr_data_i(adc_data_i),
    .rd_addr_i(res_addr_i),
    .rd_data_o(mem_rd)
  );

  // Registered result output; bus LSB weight is fixed
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      res_data_o <= {DW{1'b0}};
      bus_lsb_mv_o <= 8'h0;
    end
    else
    begin
      res_data_o <= mem_rd;
      bus_lsb_mv_o <= `TCAS_BUS_LSB_MV;
    end
  end

endmodule // tcas_sequencer

`default_nettype wire

// ### test/tcas_seq_properties.sv
/* Checker for the sequencer ports.
   Assumes binding to tcas_sequencer with a short timeout. */
`timescale 1ns/1ps
`default_nettype none
module tcas_seq_properties #(
  parameter TOUT_CYC = 200
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic cfg_wr_i,
  input wire logic [2:0] cfg_mode_i,
  input wire logic adc_done_i,
  input wire logic [2:0] mode_o,
  input wire logic [2:0] chan_en_o,
  input wire logic conversion_ready_flag_o,
  input wire logic adc_start_o,
  input wire logic [1:0] adc_chan_o,
  input wire logic adc_is_bus_o,
  input wire logic adc_power_o,
  input wire logic busy_o,
  input wire logic serial_reset_o,
  input wire logic [7:0] bus_lsb_mv_o
);
  // -----------------------------------
  // Helpers and assertions
  // -----------------------------------
  logic last_shunt;
  logic [1:0] last_chan;
  logic wr_d;
  int scl_low;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Last start was a shunt; the restart lands one cycle after a write,
  // so starts seen on both cycles belong to the aborted pass
  always @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      last_shunt <= 1'b0;
      wr_d <= 1'b0;
    end
    else
    begin
      wr_d <= cfg_wr_i;
      if (cfg_wr_i || wr_d)
        last_shunt <= 1'b0;
      else if (adc_start_o)
      begin
        last_shunt <= !adc_is_bus_o;
        last_chan <= adc_chan_o;
      end
    end
  // Raw low time of the serial clock, saturating past the limit
  always @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      scl_low <= 0;
    else if (scl_i)
      scl_low <= 0;
    else if (scl_low < TOUT_CYC + 8)
      scl_low <= scl_low + 1;
  a_mode_load: assert property (
    cfg_wr_i |=> mode_o == $past(cfg_mode_i)) else $error("mode");
  a_pd_power: assert property (
    cfg_wr_i && cfg_mode_i[1:0] == 2'b00 |=> ##3 !adc_power_o && !busy_o)
    else $error("power");
  a_pd_quiet: assert property (
    !adc_power_o |-> !adc_start_o) else $error("start in pd");
  // A start launched on the write edge still carries the old enables
  a_chan_enabled: assert property (
    adc_start_o && !wr_d |-> chan_en_o[adc_chan_o])
    else $error("disabled chan");
  a_done_next: assert property (
    adc_done_i && busy_o && !cfg_wr_i && !wr_d
    |-> ##[1:3] (adc_start_o || conversion_ready_flag_o))
    else $error("next");
  a_bus_follows: assert property (
    adc_start_o && last_shunt && mode_o[1:0] == 2'b11
    |-> adc_is_bus_o && adc_chan_o == last_chan) else $error("pair");
  a_scl_timeout: assert property (
    serial_reset_o |-> scl_low >= TOUT_CYC) else $error("early reset");
  a_lsb_weight: assert property (
    $past(rst_n_i) |-> bus_lsb_mv_o == 8'h08) else $error("lsb");
  c_bus: cover property (adc_start_o && adc_is_bus_o);
  c_flag: cover property ($rose(conversion_ready_flag_o));
  c_tout: cover property (serial_reset_o);
endmodule // tcas_seq_properties

bind tcas_sequencer tcas_seq_properties #(.TOUT_CYC(TOUT_CYC)) i_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
  .cfg_wr_i(cfg_wr_i), .cfg_mode_i(cfg_mode_i), .adc_done_i(adc_done_i),
  .mode_o(mode_o), .chan_en_o(chan_en_o), .adc_start_o(adc_start_o),
  .conversion_ready_flag_o(conversion_ready_flag_o),
  .adc_chan_o(adc_chan_o), .adc_is_bus_o(adc_is_bus_o),
  .adc_power_o(adc_power_o), .busy_o(busy_o),
  .serial_reset_o(serial_reset_o), .bus_lsb_mv_o(bus_lsb_mv_o));
`default_nettype wire

// ### test/tcas_adc_model.sv
/* Converter model: answers each start after a short or long delay.
   Assumes start, channel and kind are stable until the next start. */
`timescale 1ns/1ps
`default_nettype none
module tcas_adc_model (
  input wire logic sys_clk_i,
  input wire logic start_i,
  input wire logic [1:0] chan_i,
  input wire logic is_bus_i,
  input wire logic slow_i,
  input wire logic [7:0] tag_i,
  output wire logic done_o,
  output wire logic [15:0] data_o
);
  int cnt = 0;
  logic d = 1'b0;
  logic [15:0] q = 16'h0000;
  assign done_o = d;
  assign data_o = q;
  // Data wiggles outside done so a stale word never looks valid
  always @(posedge sys_clk_i)
  begin
    d <= 1'b0;
    q <= ~q;
    if (start_i)
      cnt <= slow_i ? 12 : 3;
    else if (cnt != 0)
      cnt <= cnt - 1;
    if (cnt == 1 && !start_i)
    begin
      d <= 1'b1;
      q <= {tag_i, 5'h00, is_bus_i, chan_i};
    end
  end
endmodule // tcas_adc_model
`default_nettype wire

// ### test/tb_top.sv
/* Bench for the sequencer against the converter model.
   Assumes shortened timeout and wake counts. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TOUT = 200;
  localparam int WAKE = 20;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl_i = 1'b1;
  logic scl_run = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic [2:0] cfg_mode_i = 3'h0;
  logic [2:0] cfg_chan_en_i = 3'h0;
  logic mask_rd_i = 1'b0;
  logic [2:0] res_addr_i = 3'h0;
  logic adc_done_i, conversion_ready_flag_o, adc_start_o, adc_is_bus_o;
  logic adc_power_o, busy_o, serial_reset_o, slow = 1'b0;
  logic [2:0] mode_o, chan_en_o, seq [$];
  logic [1:0] adc_chan_o;
  logic [15:0] adc_data_i, res_data_o, exp_res [8];
  logic [7:0] bus_lsb_mv_o, tag = 8'h00;
  int bad_count = 0, checks = 0, starts = 0, resets = 0;
  tcas_sequencer #(.TOUT_CYC(TOUT), .WAKE_CYC(WAKE)) i_tcas_sequencer (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .cfg_wr_i(cfg_wr_i), .cfg_mode_i(cfg_mode_i), .mask_rd_i(mask_rd_i),
    .cfg_chan_en_i(cfg_chan_en_i), .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i), .res_addr_i(res_addr_i), .mode_o(mode_o),
    .chan_en_o(chan_en_o), .conversion_ready_flag_o(conversion_ready_flag_o),
    .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
    .adc_is_bus_o(adc_is_bus_o), .adc_power_o(adc_power_o), .busy_o(busy_o),
    .serial_reset_o(serial_reset_o), .res_data_o(res_data_o),
    .bus_lsb_mv_o(bus_lsb_mv_o));
  tcas_adc_model i_tcas_adc_model (.sys_clk_i(sys_clk_i),
    .start_i(adc_start_o), .chan_i(adc_chan_o), .is_bus_i(adc_is_bus_o),
    .slow_i(slow), .tag_i(tag), .done_o(adc_done_i), .data_o(adc_data_i));
  always #5 sys_clk_i = ~sys_clk_i;
  always #40 if (scl_run) scl_i = ~scl_i;
  // Log starts and timeout pulses as they leave the block
  always @(posedge sys_clk_i)
  begin
    if (adc_start_o)
    begin
      seq.push_back({adc_is_bus_o, adc_chan_o});
      starts++;
    end
    if (serial_reset_o)
      resets++;
  end
  task automatic end_sim;
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic cfg(input logic [2:0] m, input logic [2:0] e);
    tick(1);
    cfg_mode_i = m;
    cfg_chan_en_i = e;
    cfg_wr_i = 1'b1;
    tick(1);
    cfg_wr_i = 1'b0;
  endtask
  // Bounded wait for the end of a pass
  task automatic wait_flag;
    int n;
    n = 0;
    while (conversion_ready_flag_o !== 1'b1 && n < 600)
    begin
      tick(1);
      n++;
    end
    chk({15'h0, conversion_ready_flag_o}, 16'h1);
  endtask
  // Expected order: ascending channels, shunt before bus
  task automatic pass_chk(input logic [2:0] m, input logic [2:0] e);
    logic [2:0] w [$];
    for (int c = 0; c < 3; c++)
      for (int b = 0; b < 2; b++)
        if (e[c] && m[b])
        begin
          w.push_back({b[0], c[1:0]});
          exp_res[{b[0], c[1:0]}] = {tag, 5'h00, b[0], c[1:0]};
        end
    chk(16'(seq.size()), 16'(w.size()));
    foreach (w[i])
      chk({13'h0, seq[i]}, {13'h0, w[i]});
  endtask
  task automatic rd_all;
    for (int a = 0; a < 7; a++)
    begin
      res_addr_i = a[2:0];
      tick(3);
      if (a != 3)
        chk(res_data_o, exp_res[a]);
    end
  endtask
  // Single passes; mode 3 twice so an unchanged write must rerun
  task automatic t_single;
    logic [2:0] m [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
    cfg(3'h0, 3'h7);
    tick(6);
    foreach (m[i])
    begin
      tag = 8'h40 + 8'(i);
      seq.delete();
      cfg(m[i], 3'h5);
      chk({15'h0, conversion_ready_flag_o}, 16'h0);
      wait_flag;
      pass_chk(m[i], 3'h5);
      tick(6);
      chk({15'h0, adc_power_o}, 16'h0);
      rd_all;
    end
  endtask
  // Slow continuous passes, mask read, power-down, wake
  task automatic t_cont;
    int s;
    tag = 8'h33;
    slow = 1'b1;
    seq.delete();
    cfg(3'h7, 3'h6);
    wait_flag;
    pass_chk(3'h7, 3'h6);
    mask_rd_i = 1'b1;
    tick(1);
    mask_rd_i = 1'b0;
    chk({15'h0, conversion_ready_flag_o}, 16'h0);
    wait_flag;
    chk(16'(seq.size()), 16'h8);
    cfg(3'h4, 3'h6);
    tick(4);
    chk({15'h0, conversion_ready_flag_o}, 16'h1);
    s = starts;
    tick(60);
    chk(16'(starts - s), 16'h0);
    rd_all;
    slow = 1'b0;
    tag = 8'h5c;
    seq.delete();
    cfg(3'h5, 3'h1);
    chk({15'h0, conversion_ready_flag_o}, 16'h0);
    tick(WAKE);
    chk(16'(seq.size()), 16'h0);
    wait_flag;
    pass_chk(3'h5, 3'h1);
    rd_all;
  endtask
  // Continuous passes straight after reset, all channels enabled
  task automatic t_boot;
    wait_flag;
    pass_chk(3'h7, 3'h7);
    chk({8'h0, bus_lsb_mv_o}, 16'h8);
  endtask
  // Serial clock held low past, then short of, the limit
  task automatic t_timeout;
    scl_run = 1'b0;
    tick(1);
    scl_i = 1'b0;
    tick(TOUT + 20);
    scl_i = 1'b1;
    chk(16'(resets), 16'h1);
    tick(5);
    scl_i = 1'b0;
    tick(TOUT - 20);
    scl_i = 1'b1;
    tick(5);
    chk(16'(resets), 16'h1);
  endtask
  initial
  begin
    tick(16);
    rst_n_i = 1'b1;
    t_boot;
    t_single;
    t_cont;
    t_timeout;
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    bad_count++;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
